// File: eews_slave.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - write-inhibit high blocks all array programming
// - inhibit pin treated low unless driven high
// - protect set blocks writes to 0x00..0x7F
// - protect cell is one-way and survives reset
// - inhibit high blocks writes regardless of protect
// - data changes only while clock is low
// - falling data with clock high is start
// - rising data with clock high is stop
// - stop after read returns to standby
// - ninth clock carries receiver acknowledge low
// - ack own address and every written byte
// - read: eight bits, ack continues, nack waits
// - type nibble must be 1010 or 0110
// - three address bits match the select pins
// - last address bit: one read, zero write
// - array is 256 bytes, eight-bit address
// - page writes take up to sixteen bytes
// - programming from stop, no ack meanwhile
// - page pointer wraps in low nibble only
// - 0110 write sets protect, 0110 read unacked
// - sequential read wraps full eight-bit counter
module eews_slave #(
  parameter int PROG_CYCLES = eews_pkg::PROG_CYCLES_DEF
) (
  // clock and resets
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        nvInit_n,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // two-wire pins
  input  wire logic        serialClockAlias,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // straps
  input  wire logic        writeInhibitPin,
  input  wire logic        selectPinBit0,
  input  wire logic        selectPinBit1,
  input  wire logic        selectPinBit2,
  // status
  output logic             standby
);
  import eews_pkg::*;

  // address match: type nibble and select bits
  function automatic logic addrHit(input logic [7:0] b,
                                   input logic [2:0] sel);
    addrHit = (b[7:4] == TYPE_MEM || b[7:4] == TYPE_PROT) &&
              (b[3:1] == sel);
  endfunction

  eews_line_t  line;          // filtered scl / sda
  eews_line_t  linePrev_ff;   // previous filtered sample
  logic [3:0]  strap;         // filtered inhibit and selects
  eews_state_t state_ff;      // frame state
  logic [3:0]  bitCnt_ff;     // 0..7 data bits, 8 = ack clock
  logic [7:0]  shift_ff;      // receive / transmit shifter
  logic        sdaOe_ff;      // pulls data low while set
  logic        cmdProt_ff;    // frame addressed with protect type
  logic [7:0]  ptr_ff;        // current address counter
  logic [7:0]  pageBuf_ff [PAGE_LEN];  // bytes awaiting programming
  logic [15:0] pageVld_ff;    // which page slots hold data
  logic [3:0]  pageHi_ff;     // page number of buffered bytes
  logic        protPend_ff;   // protect programming requested
  logic        busy_ff;       // programming in progress
  logic [31:0] progCnt_ff;    // programming time counter
  logic        wiLatch_ff;    // inhibit level taken at stop
  logic [31:0] ctrl_ff;       // control word
  logic        awHeld_ff;     // write address taken
  logic        wHeld_ff;      // write data taken
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  rdData;        // array read at the pointer
  logic        protectSet;
  eews_nvwr_t  nvWr;
  logic        protSetReq;

  // line synchronisation and filtering, idle high
  eews_line_filter #(.W(2), .RST_VAL(32'h0000_0003)) u_lineFilt (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .rawIn    ({serialClockAlias, sdaIn}),
    .cleanOut (line)
  );

  // straps pass the same synchroniser; inhibit idles low
  eews_line_filter #(.W(4), .RST_VAL(32'h0000_0000)) u_strapFilt (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .rawIn    ({writeInhibitPin, selectPinBit2, selectPinBit1,
                selectPinBit0}),
    .cleanOut (strap)
  );

  // nonvolatile array and protect cell, 256 x 8
  eews_nv_store u_store (
    .core_clk   (core_clk),
    .nvInit_n   (nvInit_n),
    .nvWr       (nvWr),
    .rdAddr     (ptr_ff),
    .rdData     (rdData),
    .protSetReq (protSetReq),
    .protectSet (protectSet)
  );

  // edge and condition decode on filtered lines
  logic sclRise, sclFall, startDet, stopDet, byteEnd, ackEnd, progDone;
  logic addrAck;
  assign sclRise  = line.scl & ~linePrev_ff.scl;
  assign sclFall  = ~line.scl & linePrev_ff.scl;
  assign startDet = line.scl & linePrev_ff.scl &
                    linePrev_ff.sda & ~line.sda;
  assign stopDet  = line.scl & linePrev_ff.scl &
                    ~linePrev_ff.sda & line.sda;
  assign byteEnd  = sclFall && bitCnt_ff == BIT_LAST;
  assign ackEnd   = sclFall && bitCnt_ff == BIT_ACK;
  assign progDone = busy_ff && progCnt_ff == 32'(PROG_CYCLES - 1);
  // own address, type pattern, not busy; 0110 read refused
  assign addrAck  = ctrl_ff[CTRL_EN_BIT] && !busy_ff &&
                    addrHit(shift_ff, strap[2:0]) &&
                    !(shift_ff[7:4] == TYPE_PROT && shift_ff[0]);

  // previous line sample for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      linePrev_ff <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      linePrev_ff <= line;
    end
  end

  // frame sequencer: bit count, shifter, acknowledge and read data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= ST_IDLE;
      bitCnt_ff  <= 4'h0;
      shift_ff   <= 8'h00;
      sdaOe_ff   <= 1'b0;
      cmdProt_ff <= 1'b0;
    end else if (stopDet) begin
      state_ff <= ST_IDLE;  // idle after any stop; standby also waits for programming
      sdaOe_ff <= 1'b0;
    end else if (startDet) begin
      state_ff  <= ST_ADDR;  // address byte follows start
      bitCnt_ff <= BIT_ACK;  // start's own clock fall is not a bit
      sdaOe_ff  <= 1'b0;
    end else if (sclRise && bitCnt_ff < BIT_ACK &&
                 state_ff != ST_RDATA) begin
      shift_ff <= {shift_ff[6:0], line.sda};
    end else if (sclRise && state_ff == ST_RDATA && line.sda &&
                 bitCnt_ff == BIT_ACK) begin
      state_ff <= ST_WAITSTOP;  // master nack ends the read
    end else if (byteEnd) begin
      bitCnt_ff <= BIT_ACK;
      case (state_ff)
        // address byte: ack when ours, direction from last bit
        ST_ADDR: begin
          sdaOe_ff   <= addrAck;
          cmdProt_ff <= shift_ff[7:4] == TYPE_PROT;
          if (!addrAck) begin
            state_ff <= ST_WAITSTOP;
          end else if (shift_ff[0]) begin
            state_ff <= ST_RDATA;
          end else begin
            state_ff <= ST_WADDR;
          end
        end
        // written bytes are always acked, even if protected
        ST_WADDR: begin
          sdaOe_ff <= 1'b1;
          state_ff <= ST_WDATA;
        end
        ST_WDATA: begin
          sdaOe_ff <= 1'b1;
        end
        // after eight read bits release for master ack
        ST_RDATA: begin
          sdaOe_ff <= 1'b0;
        end
        default: begin
          sdaOe_ff <= 1'b0;
        end
      endcase
    end else if (ackEnd) begin
      bitCnt_ff <= 4'h0;
      if (state_ff == ST_RDATA) begin
        shift_ff <= {rdData[6:0], 1'b0};
        sdaOe_ff <= ~rdData[7];  // first bit after clock falls
      end else begin
        sdaOe_ff <= 1'b0;
      end
    end else if (sclFall && bitCnt_ff < BIT_LAST) begin
      bitCnt_ff <= bitCnt_ff + 4'h1;
      if (state_ff == ST_RDATA) begin
        sdaOe_ff <= ~shift_ff[7];  // data moves on low clock
        shift_ff <= {shift_ff[6:0], 1'b0};
      end
    end
  end

  // address counter: word address load, page wrap, read increment
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ff <= 8'h00;
    end else if (byteEnd && state_ff == ST_WADDR && !cmdProt_ff) begin
      ptr_ff <= shift_ff;  // full eight-bit word address
    end else if (byteEnd && state_ff == ST_WDATA && !cmdProt_ff) begin
      ptr_ff <= {ptr_ff[7:4], ptr_ff[3:0] + 4'h1};
    end else if (byteEnd && state_ff == ST_RDATA) begin
      ptr_ff <= ptr_ff + 8'h01;  // rolls 0xff to 0x00
    end
  end

  // page buffer: up to sixteen bytes held until stop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pageVld_ff  <= 16'h0000;
      pageHi_ff   <= 4'h0;
      protPend_ff <= 1'b0;
      for (int i = 0; i < PAGE_LEN; i++) begin
        pageBuf_ff[i] <= 8'h00;
      end
    end else if (progDone) begin
      pageVld_ff  <= 16'h0000;
      protPend_ff <= 1'b0;
    end else if (byteEnd && state_ff == ST_WDATA && !cmdProt_ff) begin
      // extra bytes overwrite earlier slots of the page
      pageBuf_ff[ptr_ff[3:0]] <= shift_ff;
      pageVld_ff[ptr_ff[3:0]] <= 1'b1;
      pageHi_ff               <= ptr_ff[7:4];
    end else if (byteEnd && state_ff == ST_WADDR && cmdProt_ff) begin
      protPend_ff <= !protectSet;  // ignored once set
    end
  end

  // programming engine: starts at stop, ignores bus until done
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff    <= 1'b0;
      progCnt_ff <= 32'h0000_0000;
      wiLatch_ff <= 1'b0;
    end else if (!busy_ff) begin
      if (stopDet && (pageVld_ff != 16'h0000 || protPend_ff)) begin
        busy_ff    <= 1'b1;
        progCnt_ff <= 32'h0000_0000;
        wiLatch_ff <= strap[3];  // level taken at stop, held while programming
      end
    end else if (progDone) begin
      busy_ff <= 1'b0;
    end else begin
      progCnt_ff <= progCnt_ff + 32'h0000_0001;
    end
  end

  // one page slot per cycle; inhibit and protect skip silently
  logic [3:0] progIdx;
  assign progIdx   = progCnt_ff[3:0];
  assign nvWr.addr = {pageHi_ff, progIdx};
  assign nvWr.data = pageBuf_ff[progIdx];
  assign nvWr.en   = busy_ff && progCnt_ff < 32'(PAGE_LEN) &&
                     pageVld_ff[progIdx] &&
                     !wiLatch_ff &&
                     !(protectSet && !pageHi_ff[3]);
  // protect cell written at the end of its programming time
  assign protSetReq = progDone && protPend_ff;

  // axi write channels: address and data taken in either order
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff  <= 32'h0000_0000;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
      ctrl_ff   <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
      end
      if (awHeld_ff && wHeld_ff && !bvalid_ff) begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        // only the enable bit is writable; the rest reads as zero
        if (awAddr_ff == REG_CTRL) begin
          bresp_ff <= RESP_OKAY;
          if (s_axi_wstrb[0]) begin
            ctrl_ff[CTRL_EN_BIT] <= wData_ff[CTRL_EN_BIT];
          end
        end else begin
          bresp_ff <= RESP_SLVERR;
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // wstrb is sampled at the pairing edge, so hold it with data
  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // axi read channel: one cycle to the answer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      case (s_axi_araddr)
        REG_CTRL: rdata_ff <= ctrl_ff;
        REG_STAT: begin
          rdata_ff[STAT_BUSY_BIT]  <= busy_ff;
          rdata_ff[STAT_PROT_BIT]  <= protectSet;
          rdata_ff[STAT_WI_BIT]    <= strap[3];
          rdata_ff[STAT_STBY_BIT]  <= standby;
          rdata_ff[STAT_FRAME_BIT] <= state_ff != ST_IDLE;
        end
        REG_PTR:  rdata_ff[7:0] <= ptr_ff;
        default:  rresp_ff <= RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // open-drain data pin: only ever pulls low
  assign sdaOut  = 1'b0;
  assign sdaOe   = sdaOe_ff;
  assign standby = state_ff == ST_IDLE && !busy_ff;

  // checks on the frame sequencer and programming
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_byteDone;
    sclFall && bitCnt_ff == BIT_LAST;
  endsequence

  property p_inhibit;
    nvWr.en |-> !wiLatch_ff;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("array written while inhibit latched high");

  property p_lowProt;
    nvWr.en && protectSet |-> nvWr.addr[7];
  endproperty
  a_lowProt: assert property (p_lowProt)
    else $error("protected lower half written");

  property p_protSticky;
    protectSet |=> protectSet;
  endproperty
  a_protSticky: assert property (p_protSticky)
    else $error("protect cell cleared");

  property p_startAddr;
    startDet && !stopDet |=> state_ff == ST_ADDR && bitCnt_ff == BIT_ACK;
  endproperty
  a_startAddr: assert property (p_startAddr)
    else $error("start did not open address phase");

  property p_stopIdle;
    stopDet |=> state_ff == ST_IDLE && !sdaOe_ff;
  endproperty
  a_stopIdle: assert property (p_stopIdle)
    else $error("stop did not return to idle");

  property p_sdaLowClk;
    $changed(sdaOe_ff) |-> !linePrev_ff.scl;
  endproperty
  a_sdaLowClk: assert property (p_sdaLowClk)
    else $error("data pin moved while clock high");

  property p_busyNoAck;
    s_byteDone ##0 state_ff == ST_ADDR && busy_ff |=> !sdaOe_ff;
  endproperty
  a_busyNoAck: assert property (p_busyNoAck)
    else $error("address acked while programming");

  property p_addrMatch;
    s_byteDone ##0 state_ff == ST_ADDR && !busy_ff &&
      !addrHit(shift_ff, strap[2:0]) |=> state_ff == ST_WAITSTOP;
  endproperty
  a_addrMatch: assert property (p_addrMatch)
    else $error("foreign address not refused");

  property p_pageWrap;
    s_byteDone ##0 state_ff == ST_WDATA && !cmdProt_ff |=>
      ptr_ff[7:4] == $past(ptr_ff[7:4]) &&
      ptr_ff[3:0] == $past(ptr_ff[3:0]) + 4'h1;
  endproperty
  a_pageWrap: assert property (p_pageWrap)
    else $error("page pointer left its page");

  property p_readNack;
    sclRise && state_ff == ST_RDATA && bitCnt_ff == BIT_ACK &&
      line.sda && !stopDet && !startDet |=> state_ff == ST_WAITSTOP;
  endproperty
  a_readNack: assert property (p_readNack)
    else $error("read went on after master nack");

  property p_ackNinth;
    s_byteDone ##0 state_ff == ST_WDATA ##1 bitCnt_ff == BIT_ACK
      |-> sdaOe_ff;
  endproperty
  a_ackNinth: assert property (p_ackNinth)
    else $error("written byte not acknowledged");

endmodule

// File: eews_pkg.sv
package eews_pkg;

  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_PTR  = 8'h08;

  // control word fields and value after reset
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;

  // status word field positions
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_PROT_BIT  = 1;
  localparam int STAT_WI_BIT    = 2;
  localparam int STAT_STBY_BIT  = 3;
  localparam int STAT_FRAME_BIT = 4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // slave address type patterns
  localparam logic [3:0] TYPE_MEM  = 4'hA;
  localparam logic [3:0] TYPE_PROT = 4'h6;

  // array organisation
  localparam int         MEM_DEPTH = 256;
  localparam int         PAGE_LEN  = 16;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_LAST  = 4'h7;

  // line filter: samples a level must hold before it is believed
  localparam logic [1:0] FILT_LEN = 2'h2;

  // programming time and its cycle count at 125 MHz
  localparam int CLK_PERIOD_NS   = 8;
  localparam int PROG_TIME_NS    = 5000000;
  localparam int PROG_CYCLES_DEF =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_WAITSTOP
  } eews_state_t;

  // filtered two-wire line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } eews_line_t;

  // array write port
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } eews_nvwr_t;

endpackage

// File: eews_line_filter.sv
`timescale 1ns/1ps
module eews_line_filter #(
  parameter int          W       = 2,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // raw pins and cleaned levels
  input  wire logic [W-1:0] rawIn,
  output logic      [W-1:0] cleanOut
);
  import eews_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic       meta_ff;   // first stage, read by second only
      logic       sync_ff;   // second stage
      logic [1:0] cnt_ff;    // samples seen against current level
      logic       clean_ff;  // believed level

      // two-flop synchroniser
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_ff <= RST_VAL[i];
          sync_ff <= RST_VAL[i];
        end else begin
          meta_ff <= rawIn[i];
          sync_ff <= meta_ff;
        end
      end

      // glitch filter: a level shorter than the window never passes
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_ff   <= 2'h0;
          clean_ff <= RST_VAL[i];
        end else if (sync_ff == clean_ff) begin
          cnt_ff <= 2'h0;
        end else if (cnt_ff == FILT_LEN - 2'h1) begin
          cnt_ff   <= 2'h0;
          clean_ff <= sync_ff;
        end else begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end

      assign cleanOut[i] = clean_ff;
    end
  endgenerate

endmodule

// File: eews_nv_store.sv
`timescale 1ns/1ps
module eews_nv_store (
  // clock and nonvolatile initialisation
  input  wire logic                core_clk,
  input  wire logic                nvInit_n,
  // array ports
  input  eews_pkg::eews_nvwr_t     nvWr,
  input  wire logic [7:0]          rdAddr,
  output logic      [7:0]          rdData,
  // protect cell
  input  wire logic                protSetReq,
  output logic                     protectSet
);
  import eews_pkg::*;

  logic [7:0] mem_ff [MEM_DEPTH];  // array cells, no reset: they persist
  logic       prot_ff;             // one-way protect cell

  // array cells hold their data across any system reset
  always_ff @(posedge core_clk) begin
    if (nvWr.en) begin
      mem_ff[nvWr.addr] <= nvWr.data;
    end
  end

  // protect cell: only factory init clears it, nothing on the bus can
  always_ff @(posedge core_clk or negedge nvInit_n) begin
    if (!nvInit_n) begin
      prot_ff <= 1'b0;
    end else if (protSetReq) begin
      prot_ff <= 1'b1;
    end
  end

  assign rdData     = mem_ff[rdAddr];
  assign protectSet = prot_ff;

endmodule

// File: eews_bus_master.sv
`timescale 1ns/1ps
// behavioural bus master; its clock idles high between frames
module eews_bus_master (
  // resolved data line
  input  wire logic sdaLine,
  // driven lines; a released data line reads high through the pull-up
  output logic      scl,
  output logic      sdaDrv
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // one bit: data moves mid-low, sampled mid-high, clear of both edges
  task automatic bitx(input logic b, output logic r);
    sdaDrv = b;
    #31.25 scl = 1'b1;
    #31.25 r = sdaLine;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // data falls while clock high; also serves as repeated start
  task automatic start();
    sdaDrv = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sdaDrv = 1'b0;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // data rises while clock high, then the clock stands still
  task automatic stop();
    sdaDrv = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sdaDrv = 1'b1;
    #62.5;
  endtask
  // msb first, ninth clock released for the slave's ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // read a byte, then ack for more or leave high to end
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(!more, r);
  endtask
endmodule

// File: test_eews_slave.sv
`timescale 1ns/1ps
module test_eews_slave;
  import eews_pkg::*;
  // clock, resets, bus and pins
  logic core_clk = 1'b0, reset_n = 1'b0, nvInit_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serialClockAlias, sdaIn, sdaOut, sdaOe, sdaDrv;
  logic standby, writeInhibitPin = 1'b0, prot = 1'b0;
  logic selectPinBit0 = 1'b1, selectPinBit1 = 1'b0, selectPinBit2 = 1'b1;
  int n_fail = 0, num_checks = 0;
  logic [7:0] expMem [256]; // expected array contents
  always #4 core_clk = ~core_clk;
  // wired-and line with pull-up
  assign sdaIn = sdaDrv & ~sdaOe;
  eews_slave #(.PROG_CYCLES(400)) dut_u (.core_clk, .reset_n, .nvInit_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serialClockAlias, .sdaIn, .sdaOut, .sdaOe,
    .writeInhibitPin, .selectPinBit0, .selectPinBit1, .selectPinBit2,
    .standby);
  eews_bus_master m_u (.sdaLine(sdaIn), .scl(serialClockAlias), .sdaDrv);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  // handshakes sampled at negedge, i.e. as the next rising edge sees them
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] rsp);
    logic aw, w, b;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] rsp);
    logic ar, r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  // ack polling; the first poll must land inside programming
  task automatic poll();
    logic k;
    int n = 0;
    do begin
      m_u.start();
      m_u.wbyte(8'hAA, k);
      n++;
    end while (!k);
    m_u.stop();
    chk(n > 1, 1'b1);
  endtask
  // page write; the model keeps only bytes that inhibit and protection let through
  task automatic eeWr(input logic [7:0] wa, input logic [7:0] d0, int n);
    logic k;
    logic [7:0] a, v;
    m_u.start();
    m_u.wbyte(8'hAA, k);
    chk(k, 1'b1);
    m_u.wbyte(wa, k);
    for (int i = 0; i < n; i++) begin
      a = {wa[7:4], wa[3:0] + 4'(i)};
      v = d0 + 8'(i);
      m_u.wbyte(v, k);
      chk(k, 1'b1);
      if (!writeInhibitPin && !(prot && !a[7])) expMem[a] = v;
    end
    m_u.stop();
    poll();
  endtask
  // random then sequential read of n bytes
  task automatic eeChk(input logic [7:0] wa, input int n);
    logic k;
    logic [7:0] d;
    m_u.start();
    m_u.wbyte(8'hAA, k);
    m_u.wbyte(wa, k);
    m_u.start();
    m_u.wbyte(8'hAB, k);
    chk(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(i < n - 1, d);
      chk(d, expMem[wa + 8'(i)]);
    end
    m_u.stop();
    repeat (8) @(posedge core_clk);
    chk(standby, 1'b1);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    logic k;
    axiRd(REG_CTRL, d, r);
    chk(d, CTRL_RST);
    axiRd(8'h0C, d, r);
    chk(r, RESP_SLVERR);
    axiWr(8'h10, 32'h0000_0000, r);
    chk(r, RESP_SLVERR);
    axiWr(REG_CTRL, 32'h0000_0000, r);
    m_u.start();
    m_u.wbyte(8'hAA, k);
    chk(k, 1'b0);
    m_u.stop();
    axiWr(REG_CTRL, 32'h0000_0001, r);
    chk(r, RESP_OKAY);
    $display("t_regs done");
  endtask
  // wrong select, wrong type, protect type with read direction
  task automatic t_addr();
    logic k;
    logic [7:0] bad [3] = '{8'hA8, 8'h2A, 8'h6B};
    foreach (bad[i]) begin
      m_u.start();
      m_u.wbyte(bad[i], k);
      chk(k, 1'b0);
      m_u.stop();
    end
    $display("t_addr done");
  endtask
  task automatic t_data();
    eeWr(8'h05, 8'h11, 1);
    eeWr(8'h85, 8'h22, 1);
    eeChk(8'h05, 1);
    eeChk(8'h85, 1);
    eeWr(8'h90, 8'h40, 18); // two extra bytes wrap onto the page start
    eeChk(8'h90, 16);
    @(posedge core_clk) writeInhibitPin <= 1'b1;
    eeWr(8'h85, 8'h33, 1);
    eeChk(8'h85, 1);
    @(posedge core_clk) writeInhibitPin <= 1'b0;
    $display("t_data done");
  endtask
  // protect command, then a reset must not clear it
  task automatic t_prot();
    logic k;
    logic [31:0] d;
    logic [1:0] r;
    m_u.start();
    m_u.wbyte(8'h6A, k);
    chk(k, 1'b1);
    m_u.wbyte(8'h00, k);
    m_u.wbyte(8'h00, k);
    m_u.stop();
    poll();
    prot = 1'b1;
    eeWr(8'h05, 8'h44, 1);
    eeWr(8'h86, 8'h55, 1);
    eeChk(8'h05, 1);
    eeChk(8'h86, 1);
    @(posedge core_clk) reset_n <= 1'b0;
    @(posedge core_clk) reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    axiRd(REG_STAT, d, r);
    chk(d[STAT_PROT_BIT], 1'b1);
    eeWr(8'h05, 8'h66, 1);
    eeChk(8'h05, 1);
    $display("t_prot done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    @(posedge core_clk) nvInit_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_regs();
    t_addr();
    t_data();
    t_prot();
    report_and_stop();
  end
  // watchdog: tests take roughly 0.15 ms
  initial begin
    #400_000;
    n_fail++;
    report_and_stop();
  end
endmodule
